// ===== rtl/cbpwm_top.sv
// cbpwm_top: apb register file, input synchronisers, edge detect, pwm core
// assumes: start/stop pins asynchronous, held at least one count-clock period
//
// Contract
// - output carries pwm wave with duty set by compare values
// - rising edge on start input begins pwm generation
// - rising edge on stop input ends pwm generation
// - counter is 16-bit unsigned
// - counter runs only while count enable is set
// - ring mode counts lower to one below upper then wraps to lower
// - period is limit span times count-clock period when the counter steps by one
// - with stop-to-preset on, stop loads preset value into counter
// - output high while count >= compare a and <= compare b
// - addition mode steps counter by addition value, or by one when that value is zero
//
// The address map and the APB register port were decided locally.
`include "cbpwm_defines.svh"
module cbpwm_top
    import cbpwm_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        start_in,
    input  wire logic        stop_in,
    output logic             pwm_out
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] cmp_a;
        logic [15:0] cmp_b;
        logic [15:0] preset;
        logic [23:0] div;
        logic [1:0]  sta_sy;
        logic [1:0]  stp_sy;
        logic        sta_old;
        logic        stp_old;
        logic        sw_sta;
        logic        sw_stp;
        logic [31:0] rdata;
    } cbpwm_top_s;

    cbpwm_top_s s_q;
    cbpwm_top_s s_d;
    cbpwm_cfg_if cfg ();

    // ------------------------------------------------------------
    // register address match
    // ------------------------------------------------------------
    function automatic logic cbpwm_hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction : cbpwm_hit

    logic acc;
    logic wr;
    logic mapped;
    assign acc = psel && penable;
    assign wr  = acc && pwrite;
    assign mapped = cbpwm_hit(paddr, `CBPWM_OFS_CTRL)   || cbpwm_hit(paddr, `CBPWM_OFS_LIMIT)
                 || cbpwm_hit(paddr, `CBPWM_OFS_CMP)    || cbpwm_hit(paddr, `CBPWM_OFS_PRESET)
                 || cbpwm_hit(paddr, `CBPWM_OFS_CLKDIV) || cbpwm_hit(paddr, `CBPWM_OFS_STATUS);

    always_comb begin
        s_d        = s_q;
        // the second stage alone feeds edge detection
        s_d.sta_sy = {s_q.sta_sy[0], start_in};
        s_d.stp_sy = {s_q.stp_sy[0], stop_in};
        s_d.sta_old = s_q.sta_sy[1];
        s_d.stp_old = s_q.stp_sy[1];
        // software start/stop are one-shot pulses
        s_d.sw_sta = 1'b0;
        s_d.sw_stp = 1'b0;
        if (wr) begin
            if (cbpwm_hit(paddr, `CBPWM_OFS_CTRL)) begin
                s_d.ctrl = pwdata;
                s_d.ctrl[`CBPWM_CTRL_SWSTA] = 1'b0;
                s_d.ctrl[`CBPWM_CTRL_SWSTP] = 1'b0;
                s_d.sw_sta = pwdata[`CBPWM_CTRL_SWSTA];
                s_d.sw_stp = pwdata[`CBPWM_CTRL_SWSTP];
            end
            if (cbpwm_hit(paddr, `CBPWM_OFS_LIMIT)) begin
                s_d.lower = pwdata[15:0];
                s_d.upper = pwdata[31:16];
            end
            if (cbpwm_hit(paddr, `CBPWM_OFS_CMP)) begin
                s_d.cmp_a = pwdata[15:0];
                s_d.cmp_b = pwdata[31:16];
            end
            if (cbpwm_hit(paddr, `CBPWM_OFS_PRESET)) begin
                s_d.preset = pwdata[15:0];
            end
            if (cbpwm_hit(paddr, `CBPWM_OFS_CLKDIV)) begin
                s_d.div = pwdata[23:0];
            end
        end
        // read data is captured in setup so it stands during the access phase
        if (psel && !penable && !pwrite) begin
            s_d.rdata = '0;
            if (cbpwm_hit(paddr, `CBPWM_OFS_CTRL))   s_d.rdata = s_q.ctrl;
            if (cbpwm_hit(paddr, `CBPWM_OFS_LIMIT))  s_d.rdata = {s_q.upper, s_q.lower};
            if (cbpwm_hit(paddr, `CBPWM_OFS_CMP))    s_d.rdata = {s_q.cmp_b, s_q.cmp_a};
            if (cbpwm_hit(paddr, `CBPWM_OFS_PRESET)) s_d.rdata = {16'h0000, s_q.preset};
            if (cbpwm_hit(paddr, `CBPWM_OFS_CLKDIV)) s_d.rdata = {8'h00, s_q.div};
            if (cbpwm_hit(paddr, `CBPWM_OFS_STATUS)) begin
                s_d.rdata = {cfg.count, 13'h0000, pwm_out, 1'b0, cfg.running};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{ctrl: `CBPWM_RST_CTRL, upper: `CBPWM_RST_UPPER, lower: `CBPWM_RST_LOWER,
                     cmp_a: `CBPWM_RST_CMPA, cmp_b: `CBPWM_RST_CMPB,
                     preset: `CBPWM_RST_PRESET, div: `CBPWM_RST_DIV,
                     sta_sy: 2'h0, stp_sy: 2'h0, sta_old: 1'b0, stp_old: 1'b0,
                     sw_sta: 1'b0, sw_stp: 1'b0, rdata: 32'h0000_0000};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // apb answer: zero wait states, error on unmapped offsets
    // ------------------------------------------------------------
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign prdata  = s_q.rdata;

    // ------------------------------------------------------------
    // configuration to core
    // ------------------------------------------------------------
    assign cfg.cnt_en      = s_q.ctrl[`CBPWM_CTRL_CNTEN];
    assign cfg.add_en      = s_q.ctrl[`CBPWM_CTRL_ADDEN];
    assign cfg.stop_preset = s_q.ctrl[`CBPWM_CTRL_STPRE];
    assign cfg.add_val     = s_q.ctrl[`CBPWM_ADD_MSB:`CBPWM_ADD_LSB];
    assign cfg.upper       = s_q.upper;
    assign cfg.lower       = s_q.lower;
    assign cfg.cmp_a       = s_q.cmp_a;
    assign cfg.cmp_b       = s_q.cmp_b;
    assign cfg.preset      = s_q.preset;
    assign cfg.tick_div    = s_q.div;
    // pulses shorter than the sampling window may be lost by the far side's choice
    assign cfg.start_ev = (s_q.sta_sy[1] && !s_q.sta_old) || s_q.sw_sta;
    assign cfg.stop_ev  = (s_q.stp_sy[1] && !s_q.stp_old) || s_q.sw_stp;

    cbpwm_core u_core (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .cfg     (cfg),
        .pwm_out (pwm_out)
    );
endmodule : cbpwm_top

// ===== rtl/cbpwm_defines.svh
// cbpwm_defines.svh: register offsets, field positions, reset values, timing counts
// assumes: included by bare name from package and modules
`ifndef CBPWM_DEFINES_SVH
`define CBPWM_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CBPWM_OFS_CTRL    12'h000
`define CBPWM_OFS_LIMIT   12'h004
`define CBPWM_OFS_CMP     12'h008
`define CBPWM_OFS_PRESET  12'h00C
`define CBPWM_OFS_CLKDIV  12'h010
`define CBPWM_OFS_STATUS  12'h014

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define CBPWM_CTRL_CNTEN  0
`define CBPWM_CTRL_ADDEN  1
`define CBPWM_CTRL_STPRE  2
`define CBPWM_CTRL_SWSTA  3
`define CBPWM_CTRL_SWSTP  4
`define CBPWM_ADD_LSB     16
`define CBPWM_ADD_MSB     31

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CBPWM_RST_CTRL    32'h0000_0000
`define CBPWM_RST_UPPER   16'h000A
`define CBPWM_RST_LOWER   16'h0000
`define CBPWM_RST_CMPA    16'h0003
`define CBPWM_RST_CMPB    16'h0009
`define CBPWM_RST_PRESET  16'h0000

// ------------------------------------------------------------
// timing: count-clock period 1 ms at 10 MHz pclk
// ------------------------------------------------------------
`define CBPWM_PCLK_HZ     10000000
`define CBPWM_TICK_US     1000
`define CBPWM_TICK_CYC    ((`CBPWM_PCLK_HZ / 1000000) * `CBPWM_TICK_US)
`define CBPWM_RST_DIV     24'(`CBPWM_TICK_CYC)
`define CBPWM_DIV_W       24
`define CBPWM_ZERO16      16'h0000
`define CBPWM_ONE16       16'h0001
`define CBPWM_ONEDIV      24'h000001

`endif

// ===== rtl/cbpwm_pkg.sv
// cbpwm_pkg: shared types of the counter-based pwm block
// assumes: cbpwm_defines.svh on the include path
`include "cbpwm_defines.svh"
package cbpwm_pkg;
    typedef logic [15:0] cbpwm_cnt_t;
    typedef enum logic [1:0] {
        CBPWM_IDLE = 2'h0,
        CBPWM_RUN  = 2'h1,
        CBPWM_STOP = 2'h3
    } cbpwm_state_e;
endpackage : cbpwm_pkg

// ===== rtl/cbpwm_cfg_if.sv
// cbpwm_cfg_if: configuration carried from register file to counter core
// assumes: one pclk domain
interface cbpwm_cfg_if;
    logic        cnt_en;
    logic        add_en;
    logic        stop_preset;
    logic [15:0] add_val;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] preset;
    logic [23:0] tick_div;
    logic        start_ev;
    logic        stop_ev;
    logic        running;
    logic [15:0] count;
    modport regs (output cnt_en, add_en, stop_preset, add_val, upper, lower, cmp_a, cmp_b,
                  preset, tick_div, start_ev, stop_ev, input running, count);
    modport core (input cnt_en, add_en, stop_preset, add_val, upper, lower, cmp_a, cmp_b,
                  preset, tick_div, start_ev, stop_ev, output running, count);
endinterface : cbpwm_cfg_if

// ===== rtl/cbpwm_core.sv
// cbpwm_core: ring counter, tick divider, range compare, start/stop machine
// assumes: start/stop events are single-cycle pulses on pclk
`include "cbpwm_defines.svh"
module cbpwm_core
    import cbpwm_pkg::*;
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  ce,
    cbpwm_cfg_if.core  cfg,
    output logic       pwm_out
);
    typedef struct packed {
        cbpwm_state_e st;
        logic [23:0]  div;
        cbpwm_cnt_t   cnt;
        logic         out;
    } cbpwm_core_s;

    cbpwm_core_s s_q;
    cbpwm_core_s s_d;

    // ------------------------------------------------------------
    // next value of the ring counter
    // ------------------------------------------------------------
    function automatic cbpwm_cnt_t cbpwm_step(input cbpwm_cnt_t c, input cbpwm_cnt_t st,
                                             input cbpwm_cnt_t lo, input cbpwm_cnt_t hi);
        logic [16:0] sum;
        sum = {1'b0, c} + {1'b0, st};
        // reaching the upper limit is the same point as the lower one in a ring,
        // so at a step of one a period spans upper minus lower ticks; the 17-bit sum also catches overflow
        if (sum >= {1'b0, hi}) begin
            return lo;
        end
        return sum[15:0];
    endfunction : cbpwm_step

    always_comb begin
        logic tick;
        cbpwm_cnt_t stepv;
        s_d   = s_q;
        stepv = (cfg.add_en && cfg.add_val != `CBPWM_ZERO16) ? cfg.add_val : `CBPWM_ONE16;
        tick  = (s_q.div + `CBPWM_ONEDIV >= cfg.tick_div);
        case (s_q.st)
            CBPWM_IDLE, CBPWM_STOP: begin
                s_d.out = 1'b0;
                s_d.div = '0;
                if (cfg.start_ev && cfg.cnt_en) begin
                    s_d.st = CBPWM_RUN;
                end
            end
            CBPWM_RUN: begin
                if (cfg.stop_ev || !cfg.cnt_en) begin
                    s_d.st  = CBPWM_STOP;
                    s_d.out = 1'b0;
                    if (cfg.stop_preset) begin
                        s_d.cnt = cfg.preset;
                    end
                end else begin
                    if (tick) begin
                        s_d.div = '0;
                        s_d.cnt = cbpwm_step(s_q.cnt, stepv, cfg.lower, cfg.upper);
                    end else begin
                        s_d.div = s_q.div + `CBPWM_ONEDIV;
                    end
                    s_d.out = (s_q.cnt >= cfg.cmp_a) && (s_q.cnt <= cfg.cmp_b);
                end
            end
            default: begin
                s_d.st = CBPWM_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{st: CBPWM_IDLE, div: '0, cnt: `CBPWM_ZERO16, out: 1'b0};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign pwm_out     = s_q.out;
    assign cfg.running = (s_q.st == CBPWM_RUN);
    assign cfg.count   = s_q.cnt;
endmodule : cbpwm_core

// ===== tb/cbpwm_assertions.sv
// cbpwm_assertions: port-level checks of the pwm block
// assumes: bound to cbpwm_top, one pclk domain
module cbpwm_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        start_in,
    input wire logic        stop_in,
    input wire logic        pwm_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_acc;
    logic rd_setup;
    assign wr_acc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // output behaviour
    // ----------------------------------------
    // two sync stages plus the output register, then quiet
    a_stop_quiet: assert property ($rose(stop_in) |=> ##5 !pwm_out [*8])
        else $error("pwm_out high after stop");
    // every count lasts at least two pclk cycles with the divider used
    // a write just before or at the edge may legally cut a pulse, so it is excused
    a_high_width: assert property ($rose(pwm_out) && !$past(wr_acc) && !$past(wr_acc, 2) |-> pwm_out [*2])
        else $error("pwm_out pulse too short");
    a_ce_freeze: assert property (!ce |=> $stable(pwm_out))
        else $error("pwm_out moved with ce low");
    // ----------------------------------------
    // register bus
    // ----------------------------------------
    a_ready_high: assert property (psel && penable |-> pready)
        else $error("pready low in access");
    a_err_unmapped: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (psel && penable && paddr <= 12'h014 && paddr[1:0] == 2'h0
                                   |-> !pslverr)
        else $error("error on mapped access");
    a_err_setup: assert property (!(psel && penable) |-> !pslverr)
        else $error("pslverr outside access");
    a_rdata_hold: assert property (!$stable(prdata) |-> $past(rd_setup))
        else $error("prdata changed without read setup");
    c_pwm_rise: cover property ($rose(pwm_out));
    c_stop: cover property ($rose(stop_in));
    c_err: cover property (psel && penable && pslverr);
endmodule : cbpwm_assertions

bind cbpwm_top cbpwm_assertions u_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .start_in, .stop_in, .pwm_out);

// ===== tb/cbpwm_ext_model.sv
// cbpwm_ext_model: outside equipment driving start/stop pins, timing the pwm wave
// assumes: go bits are one-cycle requests from the bench
module cbpwm_ext_model #(
    parameter int HOLD = 16
) (
    input  wire logic       pclk,
    input  wire logic [1:0] go,
    input  wire logic       pwm_out,
    output logic            start_in,
    output logic            stop_in,
    output int              per_len,
    output int              hi_len,
    output int              rises
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] pin_q = 2'h0;
    int         hold [2] = '{0, 0};
    int         since = 0;
    int         hi = 0;
    logic       prev = 1'b0;
    assign start_in = pin_q[0];
    assign stop_in = pin_q[1];
    always @(posedge pclk) begin
        for (int i = 0; i < 2; i++) begin
            // held past one count tick so the edge is never lost
            if (go[i]) begin
                pin_q[i] <= 1'b1;
                hold[i] <= HOLD;
            end else if (hold[i] != 0) begin
                hold[i] <= hold[i] - 1;
            end else begin
                pin_q[i] <= 1'b0;
            end
        end
        prev <= pwm_out;
        hi <= pwm_out ? hi + 1 : 0;
        if (prev && !pwm_out) begin
            hi_len <= hi;
        end
        if (!prev && pwm_out) begin
            per_len <= since;
            since <= 1;
            rises <= rises + 1;
        end else begin
            since <= since + 1;
        end
    end
endmodule : cbpwm_ext_model

// ===== tb/cbpwm_bench.sv
// cbpwm_bench: register-driven test of the pwm block with a pin partner
// assumes: rtl package, interface, defines and checker compiled first
`include "cbpwm_defines.svh"
module cbpwm_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        start_in;
    logic        stop_in;
    logic        pwm_out;
    logic [1:0]  go = 2'h0;
    int          per_len;
    int          hi_len;
    int          rises;
    int          r0;
    int          error_cnt = 0;
    int          check_count = 0;
    logic [15:0] ca [3] = '{16'h0003, 16'h0001, 16'h0005};
    logic [15:0] cb [3] = '{16'h0009, 16'h0008, 16'h0005};
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    cbpwm_top DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .start_in, .stop_in, .pwm_out);
    cbpwm_ext_model u_ext (.pclk, .go, .pwm_out, .start_in, .stop_in, .per_len,
        .hi_len, .rises);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one idle cycle after each transfer keeps psel from two writes in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        chk(q, x);
        chk({31'h0, e}, {31'h0, xe});
    endtask : rd
    task automatic pulse(input int i);
        go[i] <= 1'b1;
        @(posedge pclk);
        go[i] <= 1'b0;
    endtask : pulse
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`CBPWM_OFS_CTRL, `CBPWM_RST_CTRL, 1'b0);
        rd(`CBPWM_OFS_LIMIT, {`CBPWM_RST_UPPER, `CBPWM_RST_LOWER}, 1'b0);
        rd(`CBPWM_OFS_CMP, {`CBPWM_RST_CMPB, `CBPWM_RST_CMPA}, 1'b0);
        rd(`CBPWM_OFS_PRESET, 32'(`CBPWM_RST_PRESET), 1'b0);
        rd(`CBPWM_OFS_CLKDIV, 32'(`CBPWM_TICK_CYC), 1'b0);
        rd(12'h018, 32'h0000_0000, 1'b1);
        pulse(0);
        repeat (40) @(posedge pclk);
        rd(`CBPWM_OFS_STATUS, 32'h0000_0000, 1'b0);
        wr(`CBPWM_OFS_CLKDIV, 32'h0000_0008);
        wr(`CBPWM_OFS_PRESET, 32'(`CBPWM_RST_LOWER));
        wr(`CBPWM_OFS_CTRL, 32'h0000_0005);
        pulse(0);
        // ring of ten ticks of eight cycles; the count never shows the upper limit
        for (int i = 0; i < 3; i++) begin
            wr(`CBPWM_OFS_CMP, {cb[i], ca[i]});
            repeat (250) @(posedge pclk);
            chk(32'(per_len), 32'd80);
            chk(32'(hi_len), 32'(cb[i] - ca[i] + 16'h0001) * 8);
        end
        ce <= 1'b0;
        repeat (30) @(posedge pclk);
        ce <= 1'b1;
        wr(`CBPWM_OFS_CMP, 32'h0009_0003);
        wr(`CBPWM_OFS_CTRL, 32'h0002_0007);
        repeat (250) @(posedge pclk);
        chk(32'(per_len), 32'd40);
        chk(32'(hi_len), 32'd24);
        wr(`CBPWM_OFS_CTRL, 32'h0000_0005);
        // a mid-range fall leaves a count that differs from the preset when the stop lands
        wr(`CBPWM_OFS_CMP, 32'h0005_0003);
        wait (pwm_out === 1'b1);
        wait (pwm_out === 1'b0);
        pulse(1);
        repeat (40) @(posedge pclk);
        rd(`CBPWM_OFS_STATUS, 32'h0000_0000, 1'b0);
        r0 = rises;
        repeat (300) @(posedge pclk);
        chk(32'(rises), 32'(r0));
        wr(`CBPWM_OFS_CLKDIV, 32'h0000_000A);
        wr(`CBPWM_OFS_CTRL, 32'h0000_0001);
        pulse(0);
        wait (pwm_out === 1'b1);
        wait (pwm_out === 1'b0);
        pulse(1);
        repeat (40) @(posedge pclk);
        rd(`CBPWM_OFS_STATUS, 32'h0006_0000, 1'b0);
        pulse(0);
        repeat (100) @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`CBPWM_OFS_STATUS, 32'h0000_0000, 1'b0);
        rd(`CBPWM_OFS_CTRL, `CBPWM_RST_CTRL, 1'b0);
        end_of_test();
    end
endmodule : cbpwm_bench
